//--- logic/tfp_regs.svh
// register selects, codes and reset values of the two-wire program port
// assumes inclusion by the port module and the bench
`ifndef TFP_REGS_SVH
`define TFP_REGS_SVH
`define TFP_SEL_PROG_CTL  8'h02
`define TFP_SEL_PROG_DATA 8'hb4
`define TFP_SEL_REV       8'hfe
`define TFP_SFR_ADDR_REV  8'hfe
`define TFP_SFR_PAGE_REV  4'hf
`define TFP_UNLOCK_FIRST  8'h02
`define TFP_UNLOCK_SECOND 8'h01
`define TFP_CMD_BLK_READ  8'h06
`define TFP_CMD_BLK_WRITE 8'h07
`define TFP_CMD_PAGE_ERA  8'h08
`define TFP_CMD_DEV_ERA   8'h03
`define TFP_RST_BYTE      8'h00
`define TFP_INS_DATA_RD   2'h0
`define TFP_INS_DATA_WR   2'h1
`define TFP_INS_SEL_RD    2'h2
`define TFP_INS_SEL_WR    2'h3
`endif

//--- logic/tfp_pkg.sv
// types of the two-wire program port
// assumes nothing beyond a SystemVerilog compiler
package tfp_pkg;
  typedef enum logic [2:0] {
    L_IDLE, L_INS, L_WDAT, L_WAIT, L_RDAT, L_STOP
  } tfp_link_st_t;
  typedef enum logic [1:0] {U_FIRST, U_SECOND, U_OPEN} tfp_unlock_t;
  typedef enum logic [2:0] {
    C_NONE, C_BLK_READ, C_BLK_WRITE, C_PAGE_ERASE, C_DEV_ERASE
  } tfp_cmd_t;
  // link-domain state
  typedef struct packed {
    tfp_link_st_t st;
    logic [2:0]   cnt;
    logic [1:0]   ins;
    logic [7:0]   shift;
    logic [7:0]   targetSelect;
    logic [7:0]   wdata;
    logic         wr;
    logic         reqTog;
    logic         ackS1;
    logic         ackS2;
    logic         ackSeen;
    logic         dout;
    logic         oe;
  } tfp_link_t;
  // core-domain state
  typedef struct packed {
    logic        reqS1;
    logic        reqS2;
    logic        reqSeen;
    logic        busyS1;
    logic        busyS2;
    logic        ackTog;
    logic [7:0]  rdData;
    logic [7:0]  programControl;
    tfp_unlock_t unlock;
    logic        progEn;
    logic [7:0]  programData;
    logic        opActive;
    tfp_cmd_t    cmd;
    logic        cmdStb;
    logic        byteStb;
    logic        halted;
    logic [7:0]  sfrData;
  } tfp_core_t;
endpackage

//--- logic/tfp_port.sv
// register side of the two-wire debug and flash program port
// assumes portClk is driven by the host only during frames, rst is the
// system reset, and a flash engine answers the command and byte strobes
//
// How it works
// - revision code readable at select 0xfe
// - revision code also on special-function page 0xf
// - unlock needs 0x02 then 0x01 in order
// - program mode held until system reset
// - program data at 0xb4, resets to zero
// - command bytes 06,07,08,03 decoded
// - halt core from the first frame on, until system reset
// - pins borrowed during halt, returned after
// - host selects target register before data transfers
// - host clock plus bidirectional data pin
`timescale 1ns/1ns
`include "tfp_regs.svh"
module tfp_port #(
  parameter logic [7:0] REV_CODE = 8'h5a // arbitrary value
) (
  // core clock and system reset
  input  wire logic             core_clk,
  input  wire logic             rst,
  // link pins
  input  wire logic             portClk,
  input  wire logic             dataPinIn,
  output logic                  dataPinOut,
  output logic                  dataPinOe,
  // halt and pin ownership
  output logic                  haltCore,
  output logic                  pinsBorrowed,
  // flash engine
  output logic                  progEnabled,
  output tfp_pkg::tfp_cmd_t     flashCmd,
  output logic                  flashCmdStb,
  output logic                  flashByteStb,
  output logic [7:0]            flashByte,
  input  wire logic             flashRdValid,
  input  wire logic [7:0]       flashRdByte,
  input  wire logic             flashDone,
  // special-function read port
  input  wire logic             sfrRd,
  input  wire logic [7:0]       sfrAddr,
  input  wire logic [3:0]       sfrPage,
  output logic [7:0]            sfrRdData
);
  tfp_pkg::tfp_link_t l_reg;
  tfp_pkg::tfp_link_t l_next;
  tfp_pkg::tfp_core_t c_reg;
  tfp_pkg::tfp_core_t c_next;
  logic               reqEvt;
  logic               ackEvt;

  // command byte to flash operation
  function automatic tfp_pkg::tfp_cmd_t cmdDecode(input logic [7:0] b);
    if (b == `TFP_CMD_BLK_READ) begin
      return tfp_pkg::C_BLK_READ;
    end else if (b == `TFP_CMD_BLK_WRITE) begin
      return tfp_pkg::C_BLK_WRITE;
    end else if (b == `TFP_CMD_PAGE_ERA) begin
      return tfp_pkg::C_PAGE_ERASE;
    end else if (b == `TFP_CMD_DEV_ERA) begin
      return tfp_pkg::C_DEV_ERASE;
    end else begin
      return tfp_pkg::C_NONE;
    end
  endfunction

  assign ackEvt = l_reg.ackS2 != l_reg.ackSeen;
  assign reqEvt = c_reg.reqS2 != c_reg.reqSeen;

  // link side: frame decoder on the host clock
  always_comb begin
    l_next       = l_reg;
    l_next.ackS1 = c_reg.ackTog;
    l_next.ackS2 = l_reg.ackS1;
    case (l_reg.st)
      tfp_pkg::L_IDLE: begin
        l_next.oe = 1'b0;
        if (dataPinIn) begin
          l_next.st  = tfp_pkg::L_INS;
          l_next.cnt = 3'h0;
        end
      end
      tfp_pkg::L_INS: begin
        l_next.ins[0] = dataPinIn;
        l_next.cnt    = 3'h1;
        if (l_reg.cnt == 3'h1) begin
          l_next.ins = {dataPinIn, l_reg.ins[0]};
          l_next.cnt = 3'h0;
          case ({dataPinIn, l_reg.ins[0]})
            `TFP_INS_SEL_RD: begin
              l_next.shift = l_reg.targetSelect;
              l_next.oe    = 1'b1;
              l_next.dout  = 1'b0;
              l_next.st    = tfp_pkg::L_RDAT;
            end
            `TFP_INS_DATA_RD: begin
              l_next.wr     = 1'b0;
              l_next.reqTog = ~l_reg.reqTog;
              l_next.oe     = 1'b1;
              l_next.dout   = 1'b0;
              l_next.st     = tfp_pkg::L_WAIT;
            end
            default: l_next.st = tfp_pkg::L_WDAT;
          endcase
        end
      end
      tfp_pkg::L_WDAT: begin
        l_next.shift = {dataPinIn, l_reg.shift[7:1]};
        l_next.cnt   = l_reg.cnt + 3'h1;
        if (l_reg.cnt == 3'h7) begin
          if (l_reg.ins == `TFP_INS_SEL_WR) begin
            l_next.targetSelect = {dataPinIn, l_reg.shift[7:1]};
            l_next.st           = tfp_pkg::L_STOP;
          end else begin
            l_next.wdata  = {dataPinIn, l_reg.shift[7:1]};
            l_next.wr     = 1'b1;
            l_next.reqTog = ~l_reg.reqTog;
            l_next.oe     = 1'b1;
            l_next.dout   = 1'b0;
            l_next.st     = tfp_pkg::L_WAIT;
          end
        end
      end
      tfp_pkg::L_WAIT: begin
        // core answer is stable once its toggle has crossed
        if (ackEvt) begin
          l_next.ackSeen = l_reg.ackS2;
          l_next.dout    = 1'b1;
          l_next.shift   = c_reg.rdData;
          l_next.cnt     = 3'h0;
          l_next.st      = l_reg.wr ? tfp_pkg::L_STOP : tfp_pkg::L_RDAT;
        end
      end
      tfp_pkg::L_RDAT: begin
        l_next.dout  = l_reg.shift[0];
        l_next.shift = {1'b0, l_reg.shift[7:1]};
        l_next.cnt   = l_reg.cnt + 3'h1;
        if (l_reg.cnt == 3'h7) begin
          l_next.st = tfp_pkg::L_STOP;
        end
      end
      default: begin
        l_next.oe   = 1'b0;
        l_next.dout = 1'b0;
        l_next.st   = tfp_pkg::L_IDLE;
      end
    endcase
  end

  // link registers; the host clock may stop between frames
  always_ff @(posedge portClk or posedge rst) begin
    if (rst) begin
      l_reg <= '0;
    end else begin
      l_reg <= l_next;
    end
  end

  // core side: register file, unlock and flash sequencing
  always_comb begin
    c_next         = c_reg;
    c_next.reqS1   = l_reg.reqTog;
    c_next.reqS2   = c_reg.reqS1;
    c_next.busyS1  = l_reg.st != tfp_pkg::L_IDLE;
    c_next.busyS2  = c_reg.busyS1;
    c_next.cmdStb  = 1'b0;
    c_next.byteStb = 1'b0;
    // halt is sticky; leaving needs a reset
    if (c_reg.busyS2) begin
      c_next.halted = 1'b1;
    end
    if (sfrRd && sfrAddr == `TFP_SFR_ADDR_REV
        && sfrPage == `TFP_SFR_PAGE_REV) begin
      c_next.sfrData = REV_CODE;
    end
    if (flashRdValid) begin
      c_next.programData = flashRdByte;
    end
    if (flashDone) begin
      c_next.opActive = 1'b0;
    end
    if (reqEvt) begin
      c_next.reqSeen = c_reg.reqS2;
      c_next.ackTog  = ~c_reg.ackTog;
      c_next.rdData  = `TFP_RST_BYTE;
      if (l_reg.targetSelect == `TFP_SEL_REV) begin
        c_next.rdData = REV_CODE;
      end else if (l_reg.targetSelect == `TFP_SEL_PROG_CTL) begin
        c_next.rdData = c_reg.programControl;
        if (l_reg.wr) begin
          c_next.programControl = l_reg.wdata;
          if (c_reg.unlock == tfp_pkg::U_SECOND
              && l_reg.wdata == `TFP_UNLOCK_SECOND) begin
            c_next.unlock = tfp_pkg::U_OPEN;
            c_next.progEn = 1'b1;
          end else if (c_reg.unlock != tfp_pkg::U_OPEN) begin
            c_next.unlock = (l_reg.wdata == `TFP_UNLOCK_FIRST)
                            ? tfp_pkg::U_SECOND : tfp_pkg::U_FIRST;
          end
        end
      end else if (l_reg.targetSelect == `TFP_SEL_PROG_DATA) begin
        c_next.rdData = c_reg.programData;
        if (l_reg.wr) begin
          // host byte wins over a flash byte
          c_next.programData = l_reg.wdata;
          if (c_reg.progEn && !c_reg.opActive) begin
            c_next.cmd      = cmdDecode(l_reg.wdata);
            c_next.cmdStb   = cmdDecode(l_reg.wdata) != tfp_pkg::C_NONE;
            c_next.opActive = c_next.cmdStb;
          end else if (c_reg.progEn) begin
            c_next.byteStb = 1'b1;
          end
        end
      end
    end
  end

  // core registers; progEn clears only here
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      c_reg <= '0;
    end else begin
      c_reg <= c_next;
    end
  end

  // outputs; pins follow the halt
  assign haltCore     = c_reg.halted;
  assign pinsBorrowed = c_reg.halted;
  assign dataPinOut   = l_reg.dout;
  assign dataPinOe    = l_reg.oe;
  assign progEnabled  = c_reg.progEn;
  assign flashCmd     = c_reg.cmd;
  assign flashCmdStb  = c_reg.cmdStb;
  assign flashByteStb = c_reg.byteStb;
  assign flashByte    = c_reg.programData;
  assign sfrRdData    = c_reg.sfrData;

  // checks on the core clock; the link-state checks run on the host clock
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  AST_REV_READ: assert property (
    reqEvt && l_reg.targetSelect == `TFP_SEL_REV
    |=> c_reg.rdData == REV_CODE)
    else $error("revision read wrong");
  AST_SFR_REV: assert property (
    sfrRd && sfrAddr == `TFP_SFR_ADDR_REV && sfrPage == `TFP_SFR_PAGE_REV
    |=> sfrRdData == REV_CODE)
    else $error("special-function revision wrong");
  AST_UNLOCK_ORDER: assert property (
    $rose(progEnabled) |-> $past(c_reg.unlock) == tfp_pkg::U_SECOND
    && $past(l_reg.wdata) == `TFP_UNLOCK_SECOND)
    else $error("program mode without unlock pair");
  AST_MODE_HOLD: assert property (
    progEnabled |=> progEnabled [*8])
    else $error("program mode dropped");
  AST_DATA_WRITE: assert property (
    reqEvt && l_reg.wr && l_reg.targetSelect == `TFP_SEL_PROG_DATA
    |=> flashByte == $past(l_reg.wdata))
    else $error("program data not stored");
  AST_CMD_DECODE: assert property (
    flashCmdStb |-> flashCmd == cmdDecode(flashByte) && progEnabled)
    else $error("command strobe mismatch");
  AST_HALT: assert property (
    c_reg.busyS2 |=> haltCore)
    else $error("link busy but core not halted");
  // the port may only drive the data pin once the pins are borrowed;
  // the halt sync is far shorter than the two link bits before any drive
  AST_PINS: assert property (
    dataPinOe |-> pinsBorrowed && haltCore)
    else $error("data pin driven before pins borrowed");
  // no flash strobe can leave the port before the unlock pair
  AST_LOCKED_QUIET: assert property (
    !progEnabled |-> !flashCmdStb && !flashByteStb)
    else $error("flash strobe while locked");
  AST_BAD_ORDER: assert property (
    reqEvt && l_reg.wr && l_reg.targetSelect == `TFP_SEL_PROG_CTL
    && !progEnabled && l_reg.wdata != `TFP_UNLOCK_FIRST
    && l_reg.wdata != `TFP_UNLOCK_SECOND
    |=> !progEnabled && c_reg.unlock == tfp_pkg::U_FIRST)
    else $error("broken unlock order kept state");
  AST_LINK_DRIVE: assert property (
    @(posedge portClk) disable iff (rst)
    l_reg.st == tfp_pkg::L_RDAT |-> dataPinOe)
    else $error("read bits not driven");

  COV_UNLOCK: cover property ($rose(progEnabled));
  COV_CMD: cover property (flashCmdStb ##[1:200] flashByteStb);
  COV_REV: cover property (reqEvt && l_reg.targetSelect == `TFP_SEL_REV);
  // select read back is the only frame that drives without the core
  COV_SEL_RD: cover property (@(posedge portClk) disable iff (rst)
    l_reg.st == tfp_pkg::L_RDAT && l_reg.ins == `TFP_INS_SEL_RD);
endmodule

//--- tb/tfp_host_model.sv
// host programmer model: drives the link clock and the data pin
// assumes the device answers with dataPinOut/dataPinOe on portClk rise
`timescale 1ns/1ns
module tfp_host_model (
  // device drive of the data pin
  input  wire logic dataPinOut,
  input  wire logic dataPinOe,
  // link pins seen by the device
  output logic      portClk,
  output logic      dataPinIn
);
  logic hostOut;
  logic hostOe;
  int   timeouts = 0; // frames whose ready bit never came
  // shared wire level
  // a released line shows the inverse of the host bit, never a kind value
  always_comb dataPinIn = dataPinOe ? dataPinOut : (hostOe ? hostOut : ~hostOut);
  initial begin
    portClk = 1'b0;
    hostOut = 1'b0;
    hostOe = 1'b1;
  end
  // one bit: the clock stands low between frames
  task automatic cyc(input logic b, output logic s);
    hostOut = b;
    #31 portClk = 1'b1;
    #61 s = dataPinIn;
    #1 portClk = 1'b0;
    #32;
  endtask
  // one frame; data transfers wait for ready, reads take 8 bits lsb first
  task automatic frame(input logic [1:0] ins, input logic [7:0] wb,
                       output logic [7:0] rb);
    logic s;
    int   n;
    rb = 8'h00;
    hostOe = 1'b1;
    cyc(1'b1, s);
    cyc(ins[0], s);
    cyc(ins[1], s);
    if (ins[0]) for (int i = 0; i < 8; i++) cyc(wb[i], s);
    if (ins != 2'h3) begin
      hostOe = 1'b0;
      n = 0;
      while (ins != 2'h2 && s !== 1'b1 && n < 40) begin
        cyc(1'b0, s);
        n++;
      end
      if (ins != 2'h2 && s !== 1'b1) timeouts++;
      if (!ins[0]) for (int i = 0; i < 8; i++) begin
        cyc(1'b0, s);
        rb[i] = s;
      end
    end
    hostOe = 1'b1;
    cyc(1'b0, s);
    cyc(1'b0, s);
  endtask
endmodule

//--- tb/two_wire_flash_program_port_bench.sv
// self-checking bench of the two-wire program port
// assumes tfp_port and the host model; core inputs change on falling edges
`timescale 1ns/1ns
`include "tfp_regs.svh"
module two_wire_flash_program_port_bench;
  localparam logic [7:0] REV = 8'h3c; // arbitrary value
  typedef struct packed {
    logic [7:0] sel;
    logic       wr;
    logic [7:0] wdat;
    logic [7:0] exp;
  } tfp_row_t;
  logic core_clk, rst, portClk, dataPinIn, dataPinOut, dataPinOe;
  logic haltCore, pinsBorrowed, progEnabled, flashCmdStb, flashByteStb;
  logic flashRdValid, flashDone, sfrRd;
  logic [7:0] flashByte, flashRdByte, sfrAddr, sfrRdData, rd;
  logic [3:0] sfrPage;
  tfp_pkg::tfp_cmd_t flashCmd, lastCmd;
  int err_count = 0, samples_checked = 0, cmdCount = 0, byteCount = 0, c0;
  tfp_row_t rows [6] = '{'{8'hfe, 1'b0, 8'h00, REV},
    '{8'hb4, 1'b0, 8'h00, 8'h00}, '{8'h02, 1'b0, 8'h00, 8'h00},
    '{8'h02, 1'b1, 8'h55, 8'h55}, '{8'hfe, 1'b1, 8'h99, REV},
    '{8'h37, 1'b1, 8'h66, 8'h00}};
  logic [7:0] codes [4] = '{8'h06, 8'h07, 8'h08, 8'h03};
  tfp_pkg::tfp_cmd_t kinds [4] = '{tfp_pkg::C_BLK_READ,
    tfp_pkg::C_BLK_WRITE, tfp_pkg::C_PAGE_ERASE, tfp_pkg::C_DEV_ERASE};

  tfp_port #(.REV_CODE(REV)) dut (.core_clk(core_clk), .rst(rst),
    .portClk(portClk), .dataPinIn(dataPinIn), .dataPinOut(dataPinOut),
    .dataPinOe(dataPinOe), .haltCore(haltCore), .pinsBorrowed(pinsBorrowed),
    .progEnabled(progEnabled), .flashCmd(flashCmd),
    .flashCmdStb(flashCmdStb), .flashByteStb(flashByteStb),
    .flashByte(flashByte), .flashRdValid(flashRdValid),
    .flashRdByte(flashRdByte), .flashDone(flashDone), .sfrRd(sfrRd),
    .sfrAddr(sfrAddr), .sfrPage(sfrPage), .sfrRdData(sfrRdData));
  tfp_host_model host (.dataPinOut(dataPinOut), .dataPinOe(dataPinOe),
    .portClk(portClk), .dataPinIn(dataPinIn));

  // core clock, 40 ns
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  // strobe monitor: pulses stand one core cycle; look mid-cycle, where
  // they are settled, not at the edge that launches them
  always @(negedge core_clk) begin
    if (flashCmdStb === 1'b1) begin
      cmdCount++;
      lastCmd = flashCmd;
    end
    if (flashByteStb === 1'b1) byteCount++;
  end
  task automatic check(input logic [7:0] seen, exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %0t %s: saw %h want %h", $time, what, seen, exp);
    end
  endtask
  task automatic put(input logic [7:0] sel, v);
    host.frame(`TFP_INS_SEL_WR, sel, rd);
    host.frame(`TFP_INS_DATA_WR, v, rd);
    repeat (2) @(negedge core_clk);
  endtask
  task automatic get(input logic [7:0] sel);
    host.frame(`TFP_INS_SEL_WR, sel, rd);
    host.frame(`TFP_INS_DATA_RD, 8'h00, rd);
  endtask
  task automatic do_reset();
    rst = 1'b1;
    repeat (6) @(negedge core_clk);
    rst = 1'b0;
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // watchdog: the whole run needs well under 1 ms
  initial begin
    #2000000;
    err_count++;
    final_report();
  end
  initial begin
    {flashRdValid, flashDone, sfrRd, flashRdByte, sfrAddr, sfrPage} = '0;
    do_reset();
    check({7'h0, haltCore}, 8'h00, "halt before link");
    sfrAddr = `TFP_SFR_ADDR_REV;
    sfrRd = 1'b1;
    @(negedge core_clk) sfrRd = 1'b0;
    check(sfrRdData, 8'h00, "sfr wrong page");
    sfrPage = `TFP_SFR_PAGE_REV;
    sfrRd = 1'b1;
    @(negedge core_clk) sfrRd = 1'b0;
    check(sfrRdData, REV, "sfr revision");
    $display("test sfr done");
    foreach (rows[i]) begin
      if (rows[i].wr) put(rows[i].sel, rows[i].wdat);
      get(rows[i].sel);
      check(rd, rows[i].exp, "register row");
    end
    check({6'h0, haltCore, pinsBorrowed}, 8'h03, "pins borrowed");
    host.frame(`TFP_INS_SEL_RD, 8'h00, rd);
    check(rd, 8'h37, "select readback");
    $display("test registers done");
    put(8'hb4, 8'h06);
    check(cmdCount[7:0], 8'h00, "command while locked");
    put(8'h02, 8'h02);
    put(8'h02, 8'h03);
    put(8'h02, 8'h01);
    check({7'h0, progEnabled}, 8'h00, "broken unlock");
    put(8'h02, 8'h02);
    put(8'h02, 8'h01);
    check({7'h0, progEnabled}, 8'h01, "unlock");
    $display("test unlock done");
    foreach (codes[i]) begin
      c0 = cmdCount;
      put(8'hb4, codes[i]);
      check(8'(cmdCount - c0), 8'h01, "command strobe");
      check({5'h0, lastCmd}, {5'h0, kinds[i]}, "command kind");
      c0 = byteCount;
      put(8'hb4, 8'h5e);
      check(8'(byteCount - c0), 8'h01, "operand strobe");
      check(flashByte, 8'h5e, "operand byte");
      @(negedge core_clk) flashDone = 1'b1;
      @(negedge core_clk) flashDone = 1'b0;
    end
    c0 = cmdCount;
    put(8'hb4, 8'h11);
    check(8'(cmdCount - c0), 8'h00, "bad command");
    flashRdByte = 8'ha7;
    flashRdValid = 1'b1;
    @(negedge core_clk) flashRdValid = 1'b0;
    get(8'hb4);
    check(rd, 8'ha7, "flash read byte");
    check({7'h0, progEnabled}, 8'h01, "mode held");
    $display("test commands done");
    @(negedge core_clk);
    do_reset();
    check({6'h0, progEnabled, haltCore}, 8'h00, "mode after reset");
    get(8'hb4);
    check(rd, 8'h00, "data after reset");
    check({7'h0, haltCore}, 8'h01, "halt during link");
    $display("test reset done");
    check(host.timeouts[7:0], 8'h00, "ready timeouts");
    final_report();
  end
endmodule
